/* File: rtl/cowc_pkg.sv */
package cowc_pkg;

	// ----------------------------------------------------------------
	// register map (byte offsets on the processor i/o bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] T3_COMPARE_B_LO_ADDR = 8'h9A;
	localparam logic [7:0] T3_COMPARE_B_HI_ADDR = 8'h9B;
	localparam logic [7:0] T4_COMPARE_A_LO_ADDR = 8'hAA;
	localparam logic [7:0] T4_COMPARE_A_HI_ADDR = 8'hAB;
	localparam logic [7:0] T4_COMPARE_B_LO_ADDR = 8'hAC;
	localparam logic [7:0] T4_COMPARE_B_HI_ADDR = 8'hAD;
	localparam logic [7:0] T4_WAVE_CTRL_A_ADDR  = 8'hA0;
	localparam logic [7:0] T4_WAVE_CTRL_B_ADDR  = 8'hA1;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int         CHAN_A_MODE_LSB  = 6;
	localparam int         CHAN_B_MODE_LSB  = 4;
	localparam int         WGM_LO_LSB       = 0;
	localparam int         WGM_HI_LSB       = 3;
	localparam logic [15:0] COMPARE_RESET   = 16'h0000;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [7:0]  CTRL_A_RD_MASK  = 8'hF3;
	localparam logic [7:0]  CTRL_B_RD_MASK  = 8'h18;

	// ----------------------------------------------------------------
	// output mode codes and waveform modes
	// ----------------------------------------------------------------
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR  = 2'h2;
	localparam logic [1:0] OM_SET    = 2'h3;

	localparam logic [3:0] WGM_PC_LO   = 4'h1;
	localparam logic [3:0] WGM_PC_HI   = 4'h3;
	localparam logic [3:0] WGM_FAST_LO = 4'h5;
	localparam logic [3:0] WGM_FAST_HI = 4'h7;
	localparam logic [3:0] WGM_PFC_ICR = 4'h8;
	localparam logic [3:0] WGM_PFC_OCR = 4'h9;
	localparam logic [3:0] WGM_PC_ICR  = 4'hA;
	localparam logic [3:0] WGM_PC_OCR  = 4'hB;
	localparam logic [3:0] WGM_FAST_ICR = 4'hE;
	localparam logic [3:0] WGM_FAST_OCR = 4'hF;

	typedef enum logic [1:0] {
		COWC_KIND_NONPWM = 2'b00,
		COWC_KIND_FAST   = 2'b01,
		COWC_KIND_PHASE  = 2'b11
	} cowc_kind_t;

endpackage

/* File: rtl/cowc_wave_chan.sv */
`timescale 1ns/100ps
module cowc_wave_chan
	import cowc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [1:0] output_mode,
	input  wire logic [1:0] kind,
	input  wire logic       toggle_ok,
	input  wire logic       match,
	input  wire logic       at_bottom,
	input  wire logic       at_top_cmp,
	input  wire logic       counting_down,
	output logic            wave_r,
	output logic            connected
);

	logic wave_nxt;
	logic fast_match_ok;

	// a compare value at top would glitch a full period; bottom alone acts
	assign fast_match_ok = match && !(at_top_cmp && output_mode[1]);

	assign connected = (output_mode != OM_OFF) &&
		!(output_mode == OM_TOGGLE && kind != COWC_KIND_NONPWM &&
		  !toggle_ok);

	always_comb begin
		wave_nxt = wave_r;
		case (kind)
		COWC_KIND_FAST: begin
			if (output_mode == OM_TOGGLE) begin
				if (match && toggle_ok)
					wave_nxt = !wave_r;
			end else if (output_mode[1]) begin
				if (fast_match_ok)
					wave_nxt = output_mode[0];
				else if (at_bottom)
					wave_nxt = !output_mode[0];
			end
		end
		COWC_KIND_PHASE: begin
			if (match) begin
				if (output_mode == OM_TOGGLE) begin
					if (toggle_ok)
						wave_nxt = !wave_r;
				end else if (output_mode[1]) begin
					wave_nxt = output_mode[0] ^ counting_down;
				end
			end
		end
		default: begin
			if (match) begin
				case (output_mode)
				OM_TOGGLE: wave_nxt = !wave_r;
				OM_CLEAR:  wave_nxt = 1'b0;
				OM_SET:    wave_nxt = 1'b1;
				default:   wave_nxt = wave_r;
				endcase
			end
		end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			wave_r <= 1'b0;
		else
			wave_r <= wave_nxt;
	end

endmodule

/* File: rtl/cowc_top.sv */
// Operation
// - the channel-B compare value of timer three is compared with the counter each clock.
// - equality raises a compare-match request; timer three drives no wave pin here.
// - a high-byte write goes to one shared latch; the low-byte write commits both bytes.
// - each compare register has its low byte at the base offset, high byte at base plus one.
// - a nonzero output mode field hands the pin from the port to the waveform, except code 01 in a pwm mode without toggle.
// - the output mode field is read per non-pwm, fast pwm or phase-correct waveform mode.
// - in non-pwm modes codes 00/01/10/11 mean disconnect/toggle/low/high on match.
// - fast pwm code 01 toggles channel a only in modes 14 or 15, channel b stays off.
// - fast pwm code 10 clears on match, sets at bottom; code 11 the reverse.
// - fast pwm with compare at top and upper mode bit set ignores match, acts at bottom.
// - phase-correct code 01 toggles channel a only in modes 9 or 11, else disconnected.
// - phase-correct code 10 clears on up-count match and sets on down-count match.
// - phase-correct code 11 sets on up-count match and clears on down-count match.
// - the four-bit waveform mode spans two control registers and picks the kind.
`timescale 1ns/100ps
module cowc_top
	import cowc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	input  wire logic [15:0] t3_counter_value,
	input  wire logic [15:0] t4_counter_value,
	input  wire logic [15:0] t4_top_value,
	input  wire logic        t4_counting_down,
	output logic             t3_compare_b_match,
	output logic             t4_compare_a_match,
	output logic             t4_compare_b_match,
	output logic             t4_wave_out_a,
	output logic             t4_wave_out_a_oe,
	output logic             t4_wave_out_b,
	output logic             t4_wave_out_b_oe
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]  temp_hi_r;
	logic [15:0] t3_compare_b_value_r;
	logic [15:0] t4_compare_a_value_r;
	logic [15:0] t4_compare_b_value_r;
	logic [7:0]  ctrl_a_r;
	logic [7:0]  ctrl_b_r;
	logic [7:0]  io_rdata_nxt;
	logic [15:0] rd_word;
	logic        rd_hit;

	logic wr_t3b_lo;
	logic wr_t4a_lo;
	logic wr_t4b_lo;
	logic wr_hi;
	assign wr_t3b_lo = io_wr && io_addr == T3_COMPARE_B_LO_ADDR;
	assign wr_t4a_lo = io_wr && io_addr == T4_COMPARE_A_LO_ADDR;
	assign wr_t4b_lo = io_wr && io_addr == T4_COMPARE_B_LO_ADDR;
	assign wr_hi     = io_wr && (io_addr == T3_COMPARE_B_HI_ADDR ||
		io_addr == T4_COMPARE_A_HI_ADDR ||
		io_addr == T4_COMPARE_B_HI_ADDR);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			temp_hi_r            <= CTRL_RESET;
			t3_compare_b_value_r <= COMPARE_RESET;
			t4_compare_a_value_r <= COMPARE_RESET;
			t4_compare_b_value_r <= COMPARE_RESET;
			ctrl_a_r             <= CTRL_RESET;
			ctrl_b_r             <= CTRL_RESET;
		end else begin
			if (wr_hi)
				temp_hi_r <= io_wdata;
			if (wr_t3b_lo)
				t3_compare_b_value_r <= {temp_hi_r, io_wdata};
			if (wr_t4a_lo)
				t4_compare_a_value_r <= {temp_hi_r, io_wdata};
			if (wr_t4b_lo)
				t4_compare_b_value_r <= {temp_hi_r, io_wdata};
			if (io_wr && io_addr == T4_WAVE_CTRL_A_ADDR)
				ctrl_a_r <= io_wdata & CTRL_A_RD_MASK;
			if (io_wr && io_addr == T4_WAVE_CTRL_B_ADDR)
				ctrl_b_r <= io_wdata & CTRL_B_RD_MASK;
		end
	end

	// ----------------------------------------------------------------
	// read path: compare registers read straight, no temp involved
	// ----------------------------------------------------------------
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = COMPARE_RESET;
		case ({io_addr[7:1], 1'b0})
		T3_COMPARE_B_LO_ADDR: rd_word = t3_compare_b_value_r;
		T4_COMPARE_A_LO_ADDR: rd_word = t4_compare_a_value_r;
		T4_COMPARE_B_LO_ADDR: rd_word = t4_compare_b_value_r;
		default:              rd_hit  = 1'b0;
		endcase
		if (rd_hit)
			io_rdata_nxt = io_addr[0] ? rd_word[15:8] : rd_word[7:0];
		else if (io_addr == T4_WAVE_CTRL_A_ADDR)
			io_rdata_nxt = ctrl_a_r;
		else if (io_addr == T4_WAVE_CTRL_B_ADDR)
			io_rdata_nxt = ctrl_b_r;
		else
			io_rdata_nxt = CTRL_RESET;
	end

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	logic [3:0] waveform_mode_select;
	logic [1:0] chan_a_output_mode;
	logic [1:0] chan_b_output_mode;
	logic [1:0] kind;
	logic       toggle_a_ok;
	logic       is_fast;
	logic       is_phase;

	assign waveform_mode_select = {ctrl_b_r[WGM_HI_LSB+1 -: 2],
		ctrl_a_r[WGM_LO_LSB+1 -: 2]};
	assign chan_a_output_mode = ctrl_a_r[CHAN_A_MODE_LSB+1 -: 2];
	assign chan_b_output_mode = ctrl_a_r[CHAN_B_MODE_LSB+1 -: 2];
	assign is_fast = (waveform_mode_select >= WGM_FAST_LO &&
		waveform_mode_select <= WGM_FAST_HI) ||
		waveform_mode_select == WGM_FAST_ICR ||
		waveform_mode_select == WGM_FAST_OCR;
	assign is_phase = (waveform_mode_select >= WGM_PC_LO &&
		waveform_mode_select <= WGM_PC_HI) ||
		(waveform_mode_select >= WGM_PFC_ICR &&
		 waveform_mode_select <= WGM_PC_OCR);
	assign kind = is_fast ? COWC_KIND_FAST :
		is_phase ? COWC_KIND_PHASE : COWC_KIND_NONPWM;
	assign toggle_a_ok = waveform_mode_select == WGM_FAST_ICR ||
		waveform_mode_select == WGM_FAST_OCR ||
		waveform_mode_select == WGM_PFC_OCR ||
		waveform_mode_select == WGM_PC_OCR;

	// ----------------------------------------------------------------
	// compare units
	// ----------------------------------------------------------------
	logic match_t3b;
	logic match_t4a;
	logic match_t4b;
	logic t4_bottom;
	assign match_t3b = t3_counter_value == t3_compare_b_value_r;
	assign match_t4a = t4_counter_value == t4_compare_a_value_r;
	assign match_t4b = t4_counter_value == t4_compare_b_value_r;
	assign t4_bottom = t4_counter_value == COMPARE_RESET;

	logic wave_a;
	logic wave_b;
	logic conn_a;
	logic conn_b;

	cowc_wave_chan u_chan_a (
		.clk           (clk),
		.reset_n       (reset_n),
		.output_mode   (chan_a_output_mode),
		.kind          (kind),
		.toggle_ok     (toggle_a_ok),
		.match         (match_t4a),
		.at_bottom     (t4_bottom),
		.at_top_cmp    (t4_compare_a_value_r == t4_top_value),
		.counting_down (t4_counting_down),
		.wave_r        (wave_a),
		.connected     (conn_a)
	);

	// channel b never toggles in pwm kinds
	cowc_wave_chan u_chan_b (
		.clk           (clk),
		.reset_n       (reset_n),
		.output_mode   (chan_b_output_mode),
		.kind          (kind),
		.toggle_ok     (1'b0),
		.match         (match_t4b),
		.at_bottom     (t4_bottom),
		.at_top_cmp    (t4_compare_b_value_r == t4_top_value),
		.counting_down (t4_counting_down),
		.wave_r        (wave_b),
		.connected     (conn_b)
	);

	// ----------------------------------------------------------------
	// outputs, all registered
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			io_rdata           <= CTRL_RESET;
			t3_compare_b_match <= 1'b0;
			t4_compare_a_match <= 1'b0;
			t4_compare_b_match <= 1'b0;
			t4_wave_out_a      <= 1'b0;
			t4_wave_out_a_oe   <= 1'b0;
			t4_wave_out_b      <= 1'b0;
			t4_wave_out_b_oe   <= 1'b0;
		end else begin
			io_rdata           <= io_rd ? io_rdata_nxt : CTRL_RESET;
			t3_compare_b_match <= match_t3b;
			t4_compare_a_match <= match_t4a;
			t4_compare_b_match <= match_t4b;
			t4_wave_out_a      <= wave_a;
			t4_wave_out_a_oe   <= conn_a;
			t4_wave_out_b      <= wave_b;
			t4_wave_out_b_oe   <= conn_b;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_match_request: assert property (@(posedge clk) disable iff (!reset_n)
		(t3_counter_value == t3_compare_b_value_r) |=> t3_compare_b_match)
		else $error("compare match request missing");

	a_lowbyte_commit: assert property (@(posedge clk) disable iff (!reset_n)
		wr_t3b_lo |=> t3_compare_b_value_r == {$past(temp_hi_r), $past(io_wdata)})
		else $error("low byte write did not commit both bytes");

	a_hibyte_hold: assert property (@(posedge clk) disable iff (!reset_n)
		(wr_hi && !wr_t3b_lo) |=> $stable(t3_compare_b_value_r))
		else $error("high byte write changed compare value");

	a_override_off: assert property (@(posedge clk) disable iff (!reset_n)
		(chan_a_output_mode == OM_OFF) |=> !t4_wave_out_a_oe)
		else $error("pin overridden with mode zero");

	a_fast_bottom: assert property (@(posedge clk) disable iff (!reset_n)
		(kind == COWC_KIND_FAST && chan_b_output_mode == OM_CLEAR &&
		 t4_bottom && !match_t4b) |=> wave_b)
		else $error("fast pwm did not set at bottom");

	a_fast_topskip: assert property (@(posedge clk) disable iff (!reset_n)
		(kind == COWC_KIND_FAST && chan_a_output_mode == OM_SET && match_t4a &&
		 t4_compare_a_value_r == t4_top_value && !t4_bottom)
		|=> wave_a == $past(wave_a))
		else $error("match at top was not ignored");

	a_phase_clear: assert property (@(posedge clk) disable iff (!reset_n)
		(kind == COWC_KIND_PHASE && chan_b_output_mode == OM_CLEAR &&
		 match_t4b) |=> wave_b == $past(t4_counting_down))
		else $error("phase correct code 10 wrong level");

	a_phase_set: assert property (@(posedge clk) disable iff (!reset_n)
		(kind == COWC_KIND_PHASE && chan_a_output_mode == OM_SET &&
		 match_t4a) |=> wave_a == !$past(t4_counting_down))
		else $error("phase correct code 11 wrong level");

	a_chan_b_notoggle: assert property (@(posedge clk) disable iff (!reset_n)
		(kind != COWC_KIND_NONPWM && chan_b_output_mode == OM_TOGGLE)
		|=> !t4_wave_out_b_oe)
		else $error("channel b connected in pwm toggle mode");

endmodule

/* File: testbench/tb_cowc_top.sv */
`timescale 1ns/100ps
module tb_cowc_top;
	import cowc_pkg::*;
	logic        clk;
	logic        reset_n;
	logic [7:0]  io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic [15:0] t3_cnt;
	logic [15:0] t4_cnt;
	logic [15:0] t4_top;
	logic        t4_dn;
	logic        m3, ma, mb, wa, wa_oe, wb, wb_oe;
	logic [15:0] c3_r, ca_r, cb_r, cnt;
	logic [7:0]  tmp_r, cta_r, ctb_r, rd_r;
	logic        m3_r, ma_r, mb_r, fa_r, fb_r, pa_r, pb_r, oa_r, ob_r;
	logic        dn, ph;
	logic        dir_a, dir_b, d2_latch;
	int          n_fail, checks, cycles;
	int unsigned seed;

	cowc_top u_cowc_top (
		.clk                (clk),
		.reset_n            (reset_n),
		.io_addr            (io_addr),
		.io_wr              (io_wr),
		.io_rd              (io_rd),
		.io_wdata           (io_wdata),
		.io_rdata           (io_rdata),
		.t3_counter_value   (t3_cnt),
		.t4_counter_value   (t4_cnt),
		.t4_top_value       (t4_top),
		.t4_counting_down   (t4_dn),
		.t3_compare_b_match (m3),
		.t4_compare_a_match (ma),
		.t4_compare_b_match (mb),
		.t4_wave_out_a      (wa),
		.t4_wave_out_a_oe   (wa_oe),
		.t4_wave_out_b      (wb),
		.t4_wave_out_b_oe   (wb_oe)
	);

	always #2.5 clk = ~clk;

	// ----------------------------------------------------------------
	// reference model
	// ----------------------------------------------------------------
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int kind_of(input logic [3:0] w);
		if (w inside {[4'h5:4'h7], 4'hE, 4'hF}) return 1;
		if (w inside {[4'h1:4'h3], [4'h8:4'hB]}) return 2;
		return 0;
	endfunction

	function automatic logic wave_nxt(input logic f, input logic [1:0] om,
		input logic tok, input int k, input logic hit, input logic skip,
		input logic bot, input logic down);
		if (om == 2'h0 || (om == 2'h1 && !tok)) return f;
		if (hit && !(k == 1 && skip)) begin
			if (om == 2'h1) return !f;
			return (om == 2'h3) ^ (k == 2 && down);
		end
		if (k == 1 && bot && om[1]) return om == 2'h2;
		return f;
	endfunction

	function automatic logic [7:0] rd_val(input logic [7:0] a);
		case (a)
			T3_COMPARE_B_LO_ADDR: return c3_r[7:0];
			T3_COMPARE_B_HI_ADDR: return c3_r[15:8];
			T4_COMPARE_A_LO_ADDR: return ca_r[7:0];
			T4_COMPARE_A_HI_ADDR: return ca_r[15:8];
			T4_COMPARE_B_LO_ADDR: return cb_r[7:0];
			T4_COMPARE_B_HI_ADDR: return cb_r[15:8];
			T4_WAVE_CTRL_A_ADDR:  return cta_r & CTRL_A_RD_MASK;
			T4_WAVE_CTRL_B_ADDR:  return ctb_r & CTRL_B_RD_MASK;
			default:              return 8'h00;
		endcase
	endfunction

	always @(posedge clk or negedge reset_n) begin : model
		logic [3:0] w;
		int         k;
		logic       ta, tb;
		if (!reset_n) begin
			{c3_r, ca_r, cb_r, tmp_r, cta_r, ctb_r, rd_r} <= '0;
			{m3_r, ma_r, mb_r, fa_r, fb_r, pa_r, pb_r, oa_r, ob_r} <= '0;
		end else begin
			w = {ctb_r[4:3], cta_r[1:0]};
			k = kind_of(w);
			ta = k == 0 || (k == 1 && w[3:1] == 3'h7)
				|| (k == 2 && (w == 4'h9 || w == 4'hB));
			tb = k == 0;
			rd_r <= io_rd ? rd_val(io_addr) : 8'h00;
			m3_r <= t3_cnt == c3_r;
			ma_r <= t4_cnt == ca_r;
			mb_r <= t4_cnt == cb_r;
			pa_r <= fa_r;
			pb_r <= fb_r;
			oa_r <= cta_r[7:6] != 2'h0 && (cta_r[7:6] != 2'h1 || ta);
			ob_r <= cta_r[5:4] != 2'h0 && (cta_r[5:4] != 2'h1 || tb);
			fa_r <= wave_nxt(fa_r, cta_r[7:6], ta, k, t4_cnt == ca_r,
				ca_r == t4_top && cta_r[7], t4_cnt == 16'h0000, t4_dn);
			fb_r <= wave_nxt(fb_r, cta_r[5:4], tb, k, t4_cnt == cb_r,
				cb_r == t4_top && cta_r[5], t4_cnt == 16'h0000, t4_dn);
			if (io_wr) begin
				case (io_addr)
					T3_COMPARE_B_HI_ADDR, T4_COMPARE_A_HI_ADDR,
					T4_COMPARE_B_HI_ADDR: tmp_r <= io_wdata;
					T3_COMPARE_B_LO_ADDR: c3_r <= {tmp_r, io_wdata};
					T4_COMPARE_A_LO_ADDR: ca_r <= {tmp_r, io_wdata};
					T4_COMPARE_B_LO_ADDR: cb_r <= {tmp_r, io_wdata};
					T4_WAVE_CTRL_A_ADDR:  cta_r <= io_wdata;
					T4_WAVE_CTRL_B_ADDR:  ctb_r <= io_wdata;
					default:              ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// comparison and report
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// pins are only meaningful while the waveform owns them
	always @(negedge clk) begin
		if (reset_n) begin
			chk(io_rdata, rd_r);
			chk({5'h00, m3, ma, mb}, {5'h00, m3_r, ma_r, mb_r});
			chk({6'h00, wa_oe, wb_oe}, {6'h00, oa_r, ob_r});
			if (oa_r && dir_a) chk({7'h00, wa}, {7'h00, pa_r});
			if (ob_r && dir_b && d2_latch) chk({7'h00, wb}, {7'h00, pb_r});
		end
	end

	task automatic summarize();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 12000) begin
			n_fail++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	// one bus cycle plus one counter step; every bus, count and direction input set once per step
	task automatic cyc(input logic wr, input logic rd, input logic [7:0] a,
		input logic [7:0] d);
		io_wr = wr;
		io_rd = rd;
		io_addr = a;
		io_wdata = d;
		t4_cnt = cnt;
		t3_cnt = cnt;
		t4_dn = dn;
		if (!ph) begin
			dn = 1'b0;
			cnt = (cnt >= t4_top) ? 16'h0000 : cnt + 16'h0001;
		end else if (dn) begin
			dn = cnt != 16'h0001;
			cnt = cnt - 16'h0001;
		end else begin
			// a count left at top by another mode turns straight down
			dn = cnt >= t4_top - 16'h0001;
			cnt = (cnt >= t4_top) ? cnt - 16'h0001 : cnt + 16'h0001;
		end
		@(posedge clk);
		#1;
	endtask

	task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
		cyc(1'b1, 1'b0, lo + 8'h01, v[15:8]);
		cyc(1'b1, 1'b0, lo, v[7:0]);
	endtask

	task automatic read_all();
		logic [7:0] addrs [9] = '{T3_COMPARE_B_LO_ADDR,
			T3_COMPARE_B_HI_ADDR, T4_COMPARE_A_LO_ADDR,
			T4_COMPARE_A_HI_ADDR, T4_COMPARE_B_LO_ADDR,
			T4_COMPARE_B_HI_ADDR, T4_WAVE_CTRL_A_ADDR,
			T4_WAVE_CTRL_B_ADDR, 8'h50};
		foreach (addrs[i])
			cyc(1'b0, 1'b1, addrs[i], 8'h00);
	endtask

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		{io_wr, io_rd, io_addr, io_wdata, dn, ph, t4_dn} = '0;
		dir_a = 1'b1;
		dir_b = 1'b1;
		d2_latch = 1'b1;
		cnt = 16'h0005;
		t3_cnt = cnt;
		t4_cnt = cnt;
		t4_top = 16'h0010;
		seed = 14700;
		repeat (20) @(posedge clk);
		#1;
		reset_n = 1'b1;
		read_all();
		cyc(1'b1, 1'b0, T4_WAVE_CTRL_A_ADDR, 8'hFF);
		cyc(1'b1, 1'b0, T4_WAVE_CTRL_B_ADDR, 8'hFF);
		cyc(1'b1, 1'b0, T4_COMPARE_A_HI_ADDR, 8'h5A);
		cyc(1'b1, 1'b0, T3_COMPARE_B_LO_ADDR, 8'hC3);
		read_all();
		$display("test registers done n_fail=%0d", n_fail);
		for (int w = 0; w < 16; w++) begin
			for (int m = 0; m < 4; m++) begin
				ph = kind_of(w[3:0]) == 2;
				cyc(1'b1, 1'b0, T4_WAVE_CTRL_B_ADDR, {3'h0, w[3:2], 3'h0});
				cyc(1'b1, 1'b0, T4_WAVE_CTRL_A_ADDR,
					{m[1:0], xs() % 4 == 0 ? 2'h0 : 2'(xs()), 2'h0, w[1:0]});
				wr16(T4_COMPARE_A_LO_ADDR,
					xs() % 3 == 0 ? t4_top : 16'(xs() % 17));
				wr16(T4_COMPARE_B_LO_ADDR,
					xs() % 3 == 0 ? t4_top : 16'(xs() % 17));
				wr16(T3_COMPARE_B_LO_ADDR, 16'(xs() % 17));
				repeat (40) cyc(1'b0, 1'b0, 8'h00, 8'h00);
			end
			$display("test wave mode %0d done n_fail=%0d", w, n_fail);
		end
		summarize();
	end
endmodule
